// ### verilog/tsm_top.sv
// Tach scaling, comparators, map and source selection, relay and status LED
`timescale 1ns/1ps
module tsm_top import tsm_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic tach_in, // Tach pin, asynchronous
    input wire logic map_wire_b_in, // Map switch wire, low when grounded
    input wire tsm_sense_t sense_in, // Sensor samples, core clock domain
    input wire logic [7:0] prescale_cfg_in,
    input wire logic [1:0] postscale_cfg_in,
    input wire tsm_cmp_cfg_t [2:0] cmp_cfg_in, // 0,1 map; 2 relay
    input wire logic [2:0] map_mode_in,
    input wire logic [1:0] relay_mode_in,
    input wire logic [7:0] relay_start_cnt_in,
    input wire logic [2:0] load_sel_in,
    input wire logic [1:0] baro_sel_in,
    input wire logic air_pullup_en_in,
    input wire logic trim_pullup_en_in,
    output logic [15:0] rpm_value_out,
    output logic [15:0] load_value_out,
    output logic [15:0] baro_value_out,
    output logic drv1_map_b_out,
    output logic drv2_map_b_out,
    output logic drv_table_swap_out,
    output logic relay_on_out,
    output logic status_led_out,
    output logic air_temp_pullup_out,
    output logic trim_pullup_out,
    output logic [2:0] cmp_result_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    logic [1:0] tach_sync_reg; // Two-stage synchroniser for tach
    logic [1:0] wire_sync_reg; // Two-stage synchroniser for map wire
    logic tach_prev_reg; // Last synchronised tach level
    logic prescale_loaded_reg; // Set once divisor captured after reset
    logic [7:0] prescale_reg; // Divisor in force until next power cycle
    logic [7:0] edge_cnt_reg; // Tach edges within current engine cycle
    logic cycle_pulse_reg; // One engine cycle seen
    logic [19:0] tick_cnt_reg; // Cycles toward the next 0.1 s tick
    logic tick_reg; // One-cycle 0.1 s tick
    logic [3:0] sec_cnt_reg; // Ticks within the second
    logic [15:0] cyc_cnt_reg; // Engine cycles in this second
    logic [5:0] chan_reg; // Channel outputs, two per comparator
    logic [15:0] chan_src [6]; // Selected input per channel
    logic [15:0] chan_low [6]; // Release level per channel
    logic [2:0] cmp_reg; // Combined comparator results
    tsm_rly_state_t rly_state_reg;
    logic [7:0] rly_cnt_reg; // Start-up counts left
    logic tach_rise;
    logic [23:0] rpm_next;

    // Synchronise pins; only the second stage is read by logic
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            tach_sync_reg <= 2'h0;
            wire_sync_reg <= 2'h3;
            tach_prev_reg <= 1'b0;
        end else begin
            tach_sync_reg <= {tach_sync_reg[0], tach_in};
            wire_sync_reg <= {wire_sync_reg[0], map_wire_b_in};
            tach_prev_reg <= tach_sync_reg[1];
        end
    end

    assign tach_rise = tach_sync_reg[1] && !tach_prev_reg;

    // Divisor is captured once after reset release, so a changed setting
    // waits for the next power cycle instead of upsetting a running count
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            prescale_loaded_reg <= 1'b0;
            prescale_reg <= PRESCALE_RST;
        end else if (!prescale_loaded_reg) begin
            prescale_loaded_reg <= 1'b1; // RQ3
            // Zero would never divide; treat it as one
            prescale_reg <= (prescale_cfg_in == 8'h00) ? PRESCALE_RST : prescale_cfg_in;
        end
    end

    // Divide tach edges down to one pulse per engine cycle
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            edge_cnt_reg <= 8'h00;
            cycle_pulse_reg <= 1'b0;
        end else begin
            cycle_pulse_reg <= 1'b0;
            if (tach_rise && prescale_loaded_reg) begin
                if (edge_cnt_reg + 8'h01 >= prescale_reg) begin // RQ1
                    edge_cnt_reg <= 8'h00;
                    cycle_pulse_reg <= 1'b1;
                end else begin
                    edge_cnt_reg <= edge_cnt_reg + 8'h01;
                end
            end
        end
    end

    // Time base: 0.1 s tick and tick count within the second
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
            sec_cnt_reg <= 4'h0;
        end else begin
            tick_reg <= 1'b0;
            if (tick_cnt_reg == 20'(TICK_CYC - 1)) begin
                tick_cnt_reg <= 20'h00000;
                tick_reg <= 1'b1;
                sec_cnt_reg <= (sec_cnt_reg == TICKS_PER_SEC - 4'h1) ? 4'h0 : sec_cnt_reg + 4'h1;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 20'h00001;
            end
        end
    end

    // LED lit during the first tick of every second
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            status_led_out <= 1'b0;
        end else begin
            status_led_out <= (sec_cnt_reg == 4'h0); // RQ7
        end
    end

    // Engine cycles per second times 60 times post-scale gives RPM.
    // A four-stroke cycle is one cam turn, two crank turns (post 2);
    // a two-stroke cycle is one crank turn (post 1). Resolution is
    // 60 RPM times post-scale per cycle per second, traded for a simple one-second window.
    assign rpm_next = 24'(cyc_cnt_reg) * 24'(RPM_PER_CYCLE_HZ) * 24'(postscale_cfg_in); // RQ2 RQ4

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            cyc_cnt_reg <= 16'h0000;
            rpm_value_out <= VALUE_RST;
        end else if (tick_reg && sec_cnt_reg == 4'h0) begin
            cyc_cnt_reg <= {15'h0, cycle_pulse_reg};
            // Example: 12-tooth crank, pre 24, post 2; 3-tooth two-stroke, pre 3, post 1
            rpm_value_out <= (rpm_next > 24'(RPM_MAX)) ? RPM_MAX : rpm_next[15:0]; // RQ5 RQ6
        end else if (cycle_pulse_reg && cyc_cnt_reg != 16'hFFFF) begin
            cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
        end
    end

    // Comparator channels: source mux and hysteresis latch per channel
    for (genvar k = 0; k < 6; k++) begin : g_chan
        tsm_chan_cfg_t cfg;
        assign cfg = (k % 2 == 0) ? cmp_cfg_in[k / 2].ch_a : cmp_cfg_in[k / 2].ch_b; // RQ8 RQ11

        always_comb begin
            case (cfg.sel) // RQ9
                SRC_PRIMARY: chan_src[k] = {4'h0, sense_in.primary};
                SRC_SECONDARY: chan_src[k] = {4'h0, sense_in.secondary};
                SRC_VIN1: chan_src[k] = {4'h0, sense_in.vin1};
                SRC_AIR: chan_src[k] = {4'h0, sense_in.air};
                SRC_TRIM: chan_src[k] = {4'h0, sense_in.trim};
                SRC_RPM: chan_src[k] = rpm_value_out;
                default: chan_src[k] = 16'h0000;
            endcase
            // Release point saturates at zero rather than wrapping
            chan_low[k] = (cfg.thresh > cfg.hyst) ? cfg.thresh - cfg.hyst : 16'h0000;
        end

        // Set above threshold, release only below threshold minus hysteresis
        always_ff @(posedge core_clk_in) begin
            if (!rst_b_in) begin
                chan_reg[k] <= 1'b0;
            end else if (chan_src[k] > cfg.thresh) begin
                chan_reg[k] <= 1'b1; // RQ22
            end else if (chan_src[k] < chan_low[k]) begin
                chan_reg[k] <= 1'b0; // RQ21
            end
        end

        // Combine the two channels of each comparator
        if (k % 2 == 1) begin : g_comb
            logic a;
            logic b;
            assign a = chan_reg[k - 1];
            assign b = chan_reg[k];
            always_ff @(posedge core_clk_in) begin
                if (!rst_b_in) begin
                    cmp_reg[k / 2] <= 1'b0;
                end else begin
                    case (cmp_cfg_in[k / 2].func) // RQ20
                        FN_A: cmp_reg[k / 2] <= a;
                        FN_B: cmp_reg[k / 2] <= b;
                        FN_AND: cmp_reg[k / 2] <= a & b;
                        FN_OR: cmp_reg[k / 2] <= a | b;
                        FN_XOR: cmp_reg[k / 2] <= a ^ b;
                        FN_NOT_A: cmp_reg[k / 2] <= !a;
                        FN_NOT_B: cmp_reg[k / 2] <= !b;
                        default: cmp_reg[k / 2] <= 1'b0;
                    endcase
                end
            end
        end
    end

    assign cmp_result_out = cmp_reg;

    // Map selection; map A for each driver unless a condition is active
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            drv1_map_b_out <= 1'b0;
            drv2_map_b_out <= 1'b0;
            drv_table_swap_out <= 1'b0;
        end else begin
            drv1_map_b_out <= 1'b0; // RQ19
            drv2_map_b_out <= 1'b0;
            drv_table_swap_out <= 1'b0;
            case (map_mode_in) // RQ10
                MAP_WIRE_B: begin
                    drv1_map_b_out <= !wire_sync_reg[1]; // RQ14
                    drv2_map_b_out <= !wire_sync_reg[1];
                end
                MAP_CMP1_B: begin
                    drv1_map_b_out <= cmp_reg[0];
                    drv2_map_b_out <= cmp_reg[0];
                end
                MAP_CMP2_B: begin
                    drv1_map_b_out <= cmp_reg[1];
                    drv2_map_b_out <= cmp_reg[1];
                end
                MAP_CMP1_DRV: drv_table_swap_out <= cmp_reg[0];
                MAP_CMP2_DRV: drv_table_swap_out <= cmp_reg[1];
                default: drv_table_swap_out <= 1'b0;
            endcase
        end
    end

    // Relay start-up timer; counts are loaded at reset release
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rly_state_reg <= RS_START;
            rly_cnt_reg <= 8'h00;
        end else begin
            case (rly_state_reg)
                RS_START: begin
                    if (!prescale_loaded_reg) begin
                        rly_cnt_reg <= relay_start_cnt_in;
                    end else if (rly_cnt_reg == 8'h00) begin
                        rly_state_reg <= RS_RUN;
                    end else if (tick_reg) begin
                        rly_cnt_reg <= rly_cnt_reg - 8'h01; // RQ12
                    end
                end
                RS_RUN: rly_state_reg <= RS_RUN;
                default: rly_state_reg <= RS_RUN;
            endcase
        end
    end

    // Relay drive: forced, start-up hold, or dedicated comparator
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            relay_on_out <= 1'b0;
        end else begin
            case (relay_mode_in)
                RLY_FORCE: relay_on_out <= 1'b1; // RQ13
                RLY_CMP: relay_on_out <= (rly_state_reg == RS_START) || cmp_reg[2]; // RQ11 RQ12
                default: relay_on_out <= 1'b0;
            endcase
        end
    end

    // Load and baro source selection; gauge clamps below ambient to zero
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            load_value_out <= VALUE_RST;
            baro_value_out <= VALUE_RST;
        end else begin
            case (load_sel_in) // RQ15
                LOAD_PRIMARY: load_value_out <= {4'h0, sense_in.primary};
                LOAD_SECONDARY: load_value_out <= {4'h0, sense_in.secondary};
                LOAD_GAUGE: load_value_out <= (sense_in.primary > sense_in.secondary) ?
                    {4'h0, sense_in.primary - sense_in.secondary} : 16'h0000;
                LOAD_DIFF: load_value_out <= (sense_in.secondary > sense_in.primary) ?
                    {4'h0, sense_in.secondary - sense_in.primary} : 16'h0000;
                LOAD_VIN1: load_value_out <= {4'h0, sense_in.vin1};
                default: load_value_out <= {4'h0, sense_in.primary};
            endcase
            case (baro_sel_in) // RQ16
                BARO_VIN1: baro_value_out <= {4'h0, sense_in.vin1};
                BARO_AIR: baro_value_out <= {4'h0, sense_in.air};
                BARO_TRIM: baro_value_out <= {4'h0, sense_in.trim};
                default: baro_value_out <= {4'h0, sense_in.secondary};
            endcase
        end
    end

    // Pull-up enables follow their flags
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            air_temp_pullup_out <= 1'b0;
            trim_pullup_out <= 1'b0;
        end else begin
            air_temp_pullup_out <= air_pullup_en_in; // RQ17
            trim_pullup_out <= trim_pullup_en_in; // RQ18
        end
    end

    a_prescale_frozen: assert property (prescale_loaded_reg && $past(prescale_loaded_reg)
        |-> $stable(prescale_reg)) else $error("prescale changed without reset"); // RQ3
    a_cycle_divide: assert property (cycle_pulse_reg |-> edge_cnt_reg == 8'h00 &&
        $past(tach_rise)) else $error("cycle pulse without tach edge"); // RQ1
    a_led_second: assert property ($rose(status_led_out) |-> $past(sec_cnt_reg) == 4'h0)
        else $error("led rose off the second"); // RQ7
    a_chan_set: assert property ($rose(chan_reg[0]) |-> $past(chan_src[0]) >
        $past(cmp_cfg_in[0].ch_a.thresh)) else $error("channel set below threshold"); // RQ22
    a_chan_hyst: assert property ($fell(chan_reg[0]) |-> $past(chan_src[0]) <
        $past(chan_low[0])) else $error("channel released inside hysteresis"); // RQ21
    a_map_default: assert property (map_mode_in == MAP_A_ONLY |=> !drv1_map_b_out &&
        !drv2_map_b_out && !drv_table_swap_out) else $error("map not A"); // RQ19
    a_relay_force: assert property (relay_mode_in == RLY_FORCE |=> relay_on_out)
        else $error("forced relay off"); // RQ13
    a_relay_start: assert property (relay_mode_in == RLY_CMP && rly_state_reg == RS_START
        |=> relay_on_out) else $error("relay off during start-up"); // RQ12
    a_gauge_clamp: assert property (load_sel_in == LOAD_GAUGE && sense_in.primary <=
        sense_in.secondary |=> load_value_out == 16'h0000) else $error("gauge not clamped"); // RQ15
    a_pullup_follow: assert property (##1 air_temp_pullup_out == $past(air_pullup_en_in))
        else $error("air pull-up mismatch"); // RQ17
endmodule

// ### verilog/tsm_pkg.sv
// Package: constants, types and the behaviour list for tach scaling and map select logic
// Behaviour
// (RQ1) Pre-scaler divides tach pulses to engine cycles
// (RQ2) Engine cycle is cam or crank revolution
// (RQ3) Pre-scaler value applied only after power cycle
// (RQ4) Post-scaler two for four-stroke, one two-stroke
// (RQ5) Pre 24, post 2 gives correct RPM
// (RQ6) Pre 3, post 1 gives correct RPM
// (RQ7) Status LED pulses once each second
// (RQ8) Map comparators: two channels, input, threshold, hysteresis
// (RQ9) Channel inputs: pressures, voltages or RPM
// (RQ10) Four maps; comparator picks A/B or driver
// (RQ11) Dedicated dual comparator drives auxiliary relay
// (RQ12) Start-up timer holds relay, 0.1 s counts
// (RQ13) Relay option forces relay on for testing
// (RQ14) Map switching may follow grounded external wire
// (RQ15) Load source selectable; sensor difference gives gauge
// (RQ16) Baro source defaults to secondary pressure sensor
// (RQ17) Air temp pull-up follows its flag
// (RQ18) Trim input has selectable pull-up
// (RQ19) No switch condition means map A
// (RQ20) Channel results combined by selectable boolean function
// (RQ21) Hysteresis around threshold prevents chatter
// (RQ22) Set above threshold, clear below threshold minus hysteresis
package tsm_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 100_000_000; // One relay timer count, 0.1 s
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] TICKS_PER_SEC = 4'hA;
    localparam logic [15:0] RPM_PER_CYCLE_HZ = 16'h003C; // 60 s per minute
    localparam logic [15:0] RPM_MAX = 16'hFFFF;
    // Reset values
    localparam logic [7:0] PRESCALE_RST = 8'h01;
    localparam logic [15:0] VALUE_RST = 16'h0000;
    // Channel source codes
    localparam logic [2:0] SRC_PRIMARY = 3'h0;
    localparam logic [2:0] SRC_SECONDARY = 3'h1;
    localparam logic [2:0] SRC_VIN1 = 3'h2;
    localparam logic [2:0] SRC_AIR = 3'h3;
    localparam logic [2:0] SRC_TRIM = 3'h4;
    localparam logic [2:0] SRC_RPM = 3'h5;
    // Boolean combine codes
    localparam logic [2:0] FN_A = 3'h0;
    localparam logic [2:0] FN_B = 3'h1;
    localparam logic [2:0] FN_AND = 3'h2;
    localparam logic [2:0] FN_OR = 3'h3;
    localparam logic [2:0] FN_XOR = 3'h4;
    localparam logic [2:0] FN_NOT_A = 3'h5;
    localparam logic [2:0] FN_NOT_B = 3'h6;
    // Map select modes
    localparam logic [2:0] MAP_A_ONLY = 3'h0;
    localparam logic [2:0] MAP_WIRE_B = 3'h1;
    localparam logic [2:0] MAP_CMP1_B = 3'h2;
    localparam logic [2:0] MAP_CMP2_B = 3'h3;
    localparam logic [2:0] MAP_CMP1_DRV = 3'h4;
    localparam logic [2:0] MAP_CMP2_DRV = 3'h5;
    // Relay modes
    localparam logic [1:0] RLY_OFF = 2'h0;
    localparam logic [1:0] RLY_CMP = 2'h1;
    localparam logic [1:0] RLY_FORCE = 2'h2;
    // Load sources
    localparam logic [2:0] LOAD_PRIMARY = 3'h0;
    localparam logic [2:0] LOAD_SECONDARY = 3'h1;
    localparam logic [2:0] LOAD_GAUGE = 3'h2;
    localparam logic [2:0] LOAD_DIFF = 3'h3;
    localparam logic [2:0] LOAD_VIN1 = 3'h4;
    // Baro sources
    localparam logic [1:0] BARO_SECONDARY = 2'h0;
    localparam logic [1:0] BARO_VIN1 = 2'h1;
    localparam logic [1:0] BARO_AIR = 2'h2;
    localparam logic [1:0] BARO_TRIM = 2'h3;
    // Sensor sample bundle
    typedef struct packed {
        logic [11:0] primary;
        logic [11:0] secondary;
        logic [11:0] vin1;
        logic [11:0] air;
        logic [11:0] trim;
    } tsm_sense_t;
    // One comparator channel
    typedef struct packed {
        logic [2:0] sel;
        logic [15:0] thresh;
        logic [15:0] hyst;
    } tsm_chan_cfg_t;
    // One dual comparator
    typedef struct packed {
        tsm_chan_cfg_t ch_b;
        tsm_chan_cfg_t ch_a;
        logic [2:0] func;
    } tsm_cmp_cfg_t;
    // Relay start-up state
    typedef enum logic [1:0] {
        RS_START = 2'b01,
        RS_RUN = 2'b10
    } tsm_rly_state_t;
endpackage

// ### bench/tsm_tach_model.sv
// Engine tach source model: periodic pulses with set high and low times
`timescale 1ns/1ps
module tsm_tach_model (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic [3:0] hi_cyc_in,
    input wire logic [3:0] lo_cyc_in,
    output logic tach_out
);
    logic [3:0] cnt_reg; // Cycles spent in the present level

    // Toggle on falling edges; each level lasts at least two cycles as the sync needs
    always @(negedge clk_in) begin
        if (!en_in) begin
            cnt_reg <= 4'h0;
            tach_out <= 1'b0;
        end else if (cnt_reg == (tach_out ? hi_cyc_in : lo_cyc_in) - 4'h1) begin
            cnt_reg <= 4'h0;
            tach_out <= ~tach_out;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

// ### bench/tsm_top_tb_top.sv
// Self-checking bench for tach scaling, comparators, selection, relay and LED
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tsm_top_tb_top;
    import tsm_pkg::*;
    localparam int TICK = 12; // Short tick; one second is then 120 cycles
    localparam int SEC = 10 * TICK;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic map_wire_b_in = 1'b1; // Wire open
    logic tach_en = 1'b0;
    logic [3:0] tach_hi = 4'h2;
    logic [3:0] tach_lo = 4'h3;
    logic tach_w;
    tsm_sense_t sense = '0;
    logic [7:0] prescale = 8'h18;
    logic [1:0] postscale = 2'h2;
    tsm_cmp_cfg_t [2:0] cmp_cfg = '0;
    logic [2:0] map_mode = MAP_A_ONLY;
    logic [1:0] relay_mode = RLY_OFF;
    logic [7:0] relay_start = 8'h02;
    logic [2:0] load_sel = LOAD_PRIMARY;
    logic [1:0] baro_sel = BARO_SECONDARY;
    logic air_pu = 1'b0;
    logic trim_pu = 1'b0;
    logic [15:0] rpm_w, load_w, baro_w;
    logic map1_w, map2_w, swap_w, relay_w, led_w, air_w, trim_w;
    logic [2:0] res_w;
    int failures = 0;
    int cmp_count = 0;
    int led_cnt;
    logic [15:0] exp16;
    logic [2:0] exp3;

    tsm_tach_model tach_u (.clk_in(core_clk_in), .en_in(tach_en), .hi_cyc_in(tach_hi),
        .lo_cyc_in(tach_lo), .tach_out(tach_w));

    tsm_top #(.TICK_CYC(TICK)) dut_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .tach_in(tach_w), .map_wire_b_in(map_wire_b_in), .sense_in(sense),
        .prescale_cfg_in(prescale), .postscale_cfg_in(postscale), .cmp_cfg_in(cmp_cfg),
        .map_mode_in(map_mode), .relay_mode_in(relay_mode), .relay_start_cnt_in(relay_start),
        .load_sel_in(load_sel), .baro_sel_in(baro_sel), .air_pullup_en_in(air_pu),
        .trim_pullup_en_in(trim_pu), .rpm_value_out(rpm_w), .load_value_out(load_w),
        .baro_value_out(baro_w), .drv1_map_b_out(map1_w), .drv2_map_b_out(map2_w),
        .drv_table_swap_out(swap_w), .relay_on_out(relay_w), .status_led_out(led_w),
        .air_temp_pullup_out(air_w), .trim_pullup_out(trim_w), .cmp_result_out(res_w));

    // 10 MHz core clock
    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end

    // Reference for the boolean combine codes; unknown codes give 0
    function automatic logic fn_exp(input logic [2:0] f, input logic a, input logic b);
        case (f)
            FN_A: return a;
            FN_B: return b;
            FN_AND: return a & b;
            FN_OR: return a | b;
            FN_XOR: return a ^ b;
            FN_NOT_A: return ~a;
            FN_NOT_B: return ~b;
            default: return 1'b0;
        endcase
    endfunction

    // Power cycle stand-in: reset held eight cycles, released on a falling edge
    task automatic reset_dut();
        rst_b_in = 1'b0;
        repeat (8) @(negedge core_clk_in);
        rst_b_in = 1'b1;
    endtask

    // Let the three-stage comparator and map path settle
    task automatic settle();
        repeat (5) @(negedge core_clk_in);
    endtask

    // Print the verdict and stop
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 14 seconds of 120 cycles
    initial begin
        repeat (40 * SEC) @(posedge core_clk_in);
        failures++;
        wrap_up();
    end

    initial begin
        // Channel a on primary, b on secondary, both 100 with 20 hysteresis
        cmp_cfg[0].ch_a = '{sel: SRC_PRIMARY, thresh: 16'h0064, hyst: 16'h0014};
        cmp_cfg[0].ch_b = '{sel: SRC_SECONDARY, thresh: 16'h0064, hyst: 16'h0014};
        cmp_cfg[1].ch_a = '{sel: SRC_TRIM, thresh: 16'h0FA0, hyst: 16'h0000};
        cmp_cfg[2].ch_a = '{sel: SRC_VIN1, thresh: 16'h00C8, hyst: 16'h0000};
        @(negedge core_clk_in);
        tach_en = 1'b1;
        reset_dut();
        // Twelve-tooth crank, four-stroke: one engine cycle per second
        repeat (3 * SEC) @(negedge core_clk_in);
        `CHK("rpm 24/2", 16'h0078, rpm_w)
        prescale = 8'h03;
        repeat (2 * SEC) @(negedge core_clk_in);
        `CHK("rpm before power cycle", 16'h0078, rpm_w)
        led_cnt = 0;
        for (int i = 0; i < SEC; i++) begin
            @(negedge core_clk_in);
            if (led_w === 1'b1) led_cnt++;
        end
        `CHK("led lit cycles", TICK, led_cnt)
        // Three-tooth crank, two-stroke, applied after the power cycle
        tach_hi = 4'h2;
        tach_lo = 4'h2;
        postscale = 2'h1;
        relay_mode = RLY_CMP;
        reset_dut();
        repeat (5) @(negedge core_clk_in);
        `CHK("relay start hold", 1'b1, relay_w)
        repeat (60) @(negedge core_clk_in);
        `CHK("relay after hold", 1'b0, relay_w)
        sense.vin1 = 12'h0FA;
        settle();
        `CHK("relay by comparator", 1'b1, relay_w)
        sense.vin1 = 12'h000;
        relay_mode = RLY_FORCE;
        settle();
        `CHK("relay forced", 1'b1, relay_w)
        relay_mode = RLY_OFF;
        settle();
        `CHK("relay off", 1'b0, relay_w)
        repeat (3 * SEC) @(negedge core_clk_in);
        `CHK("rpm 3/1", 16'h0258, rpm_w)
        postscale = 2'h2;
        repeat (2 * SEC) @(negedge core_clk_in);
        `CHK("rpm 3/2", 16'h04B0, rpm_w)
        // Hysteresis: set strictly above 100, clear strictly below 80
        sense.primary = 12'h064;
        settle();
        `CHK("hyst at thresh", 1'b0, res_w[0])
        sense.primary = 12'h065;
        settle();
        `CHK("hyst set", 1'b1, res_w[0])
        sense.primary = 12'h050;
        settle();
        `CHK("hyst hold", 1'b1, res_w[0])
        sense.primary = 12'h04F;
        settle();
        `CHK("hyst clear", 1'b0, res_w[0])
        // Every combine code over three input pairs
        for (int f = 0; f < 8; f++) begin
            for (int c = 1; c < 4; c++) begin
                cmp_cfg[0].func = f[2:0];
                sense.primary = c[0] ? 12'h096 : 12'h000;
                sense.secondary = c[1] ? 12'h096 : 12'h000;
                settle();
                `CHK("combine", fn_exp(f[2:0], c[0], c[1]), res_w[0])
            end
        end
        // Map modes with comparator 1 true, comparator 2 false, wire grounded
        cmp_cfg[0].func = FN_A;
        sense.primary = 12'h096;
        sense.secondary = 12'h000;
        map_wire_b_in = 1'b0;
        for (int m = 0; m < 8; m++) begin
            map_mode = m[2:0];
            exp3 = (m == 1 || m == 2) ? 3'h6 : (m == 4) ? 3'h1 : 3'h0;
            settle();
            `CHK("map outputs", exp3, {map1_w, map2_w, swap_w})
        end
        map_mode = MAP_WIRE_B;
        map_wire_b_in = 1'b1;
        settle();
        `CHK("map wire open", 3'h0, {map1_w, map2_w, swap_w})
        // Comparator 2 on RPM (1200) above 1024 picks map B, then swaps driver tables
        cmp_cfg[1].ch_a = '{sel: SRC_RPM, thresh: 16'h0400, hyst: 16'h0000};
        map_mode = MAP_CMP2_B;
        settle();
        `CHK("cmp2 on rpm", 1'b1, res_w[1])
        `CHK("map by cmp2", 3'h6, {map1_w, map2_w, swap_w})
        map_mode = MAP_CMP2_DRV;
        settle();
        `CHK("tables by cmp2", 3'h1, {map1_w, map2_w, swap_w})
        // Load and baro sources
        sense = '{primary: 12'h12C, secondary: 12'h064, vin1: 12'h037, air: 12'h0AB,
            trim: 12'h0CD};
        for (int s = 0; s < 6; s++) begin
            load_sel = (s == 5) ? 3'h7 : s[2:0];
            case (s)
                1: exp16 = 16'h0064;
                2: exp16 = 16'h00C8;
                3: exp16 = 16'h0000;
                4: exp16 = 16'h0037;
                default: exp16 = 16'h012C;
            endcase
            settle();
            `CHK("load source", exp16, load_w)
        end
        // Secondary above primary: gauge clamps at zero
        load_sel = LOAD_GAUGE;
        sense.secondary = 12'h1F4;
        settle();
        `CHK("gauge clamp", 16'h0000, load_w)
        for (int s = 0; s < 4; s++) begin
            baro_sel = s[1:0];
            exp16 = {4'h0, (s == 0) ? sense.secondary : (s == 1) ? sense.vin1 :
                (s == 2) ? sense.air : sense.trim};
            settle();
            `CHK("baro source", exp16, baro_w)
        end
        // Pull-up flags, each on and off
        air_pu = 1'b1;
        settle();
        `CHK("pull-ups", 2'h2, {air_w, trim_w})
        air_pu = 1'b0;
        trim_pu = 1'b1;
        settle();
        `CHK("pull-ups", 2'h1, {air_w, trim_w})
        wrap_up();
    end
endmodule
